// [hw/amcd_decoder.sv]
// Miscellaneous command decoder with Wishbone register access
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module amcd_decoder
   import amcd_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire amcd_axis_in_s [AXES-1:0] axisIn,
   output amcd_axis_out_s [AXES-1:0] axisOut,
   output logic triangleGuardOff,
   output logic maxFinishClear,
   output logic timerExpired
);
   // ==========================================
   // Bus and command decode
   logic softReset_r;
   logic rstAll;
   logic busWrite;
   logic cmdWrite;
   logic [7:0] cmdHigh;
   logic [7:0] cmdCode;
   logic [AXES-1:0] axisSel;
   logic [7:0] cmdHigh_r;
   logic [7:0] cmdLow_r;
   logic [31:0] mode3_r;
   amcd_speed_t step_r;
   amcd_speed_t driveSpeed_r;
   logic [31:0] timerLimit_r;
   logic [31:0] devCfg_r;
   logic [31:0] splitCfg_r;
   logic [31:0] readData;

   assign busWrite = cyc_i && stb_i && we_i && !ack_o;
   assign cmdWrite = busWrite && adr_i == ADDR_COMMAND && sel_i[0];
   assign cmdHigh = sel_i[1] ? dat_i[15:8] : cmdHigh_r;
   assign cmdCode = dat_i[7:0];
   assign axisSel = cmdHigh[AXES-1:0];
   // The reset pulse is registered so the acknowledging write finishes cleanly first
   assign rstAll = reset || softReset_r;

   always_ff @(posedge clock) begin
      if (reset) begin
         softReset_r <= 1'b0;
      end else begin
         softReset_r <= cmdWrite && cmdCode == CMD_RESET && cmdHigh == RESET_HIGH_BYTE;
      end
   end

   // ==========================================
   // Setting registers
   always_ff @(posedge clock) begin
      if (rstAll) begin
         cmdHigh_r <= REG_RESET[7:0];
         cmdLow_r <= REG_RESET[7:0];
         mode3_r <= REG_RESET;
         step_r <= REG_RESET[SPEED_W-1:0];
         driveSpeed_r <= REG_RESET[SPEED_W-1:0];
         timerLimit_r <= REG_RESET;
         devCfg_r <= REG_RESET;
         splitCfg_r <= REG_RESET;
      end else if (busWrite) begin
         if (adr_i == ADDR_COMMAND) begin
            if (sel_i[1]) begin
               cmdHigh_r <= dat_i[15:8];
            end
            if (sel_i[0]) begin
               cmdLow_r <= dat_i[7:0];
            end
         end else if (adr_i == ADDR_MODE3) begin
            mode3_r <= dat_i;
         end else if (adr_i == ADDR_STEP) begin
            step_r <= dat_i[SPEED_W-1:0];
         end else if (adr_i == ADDR_DRIVE_SPEED) begin
            driveSpeed_r <= dat_i[SPEED_W-1:0];
         end else if (adr_i == ADDR_TIMER_LIMIT) begin
            timerLimit_r <= dat_i;
         end else if (adr_i == ADDR_DEV_CFG) begin
            devCfg_r <= dat_i;
         end else if (adr_i == ADDR_SPLIT_CFG) begin
            splitCfg_r <= dat_i;
         end
      end
   end

   assign triangleGuardOff = mode3_r[MODE3_TRI_OFF_BIT];

   // ==========================================
   // Speed, drive start hold and release
   amcd_speed_t speed_r [AXES];
   logic [AXES-1:0] hold_r;
   logic [AXES-1:0] pending_r;
   logic [AXES-1:0] driveStart_r;
   logic [AXES-1:0] speedOk;
   logic release_w;

   assign release_w = cmdWrite && cmdCode == CMD_RELEASE;

   always_comb begin
      for (int a = 0; a < AXES; a++) begin
         speedOk[a] = axisSel[a] && axisIn[a].driving && !axisIn[a].interp
            && (!axisIn[a].sCurve || axisIn[a].constSpeed);
      end
   end

   always_ff @(posedge clock) begin
      if (rstAll) begin
         hold_r <= '0;
         pending_r <= '0;
         driveStart_r <= '0;
      end else begin
         for (int a = 0; a < AXES; a++) begin
            if (release_w) begin
               driveStart_r[a] <= pending_r[a] || axisIn[a].driveReq;
               hold_r[a] <= 1'b0;
               pending_r[a] <= 1'b0;
            end else if (hold_r[a] || (cmdWrite && cmdCode == CMD_HOLD && axisSel[a])) begin
               driveStart_r[a] <= 1'b0;
               hold_r[a] <= 1'b1;
               pending_r[a] <= pending_r[a] || axisIn[a].driveReq;
            end else begin
               driveStart_r[a] <= axisIn[a].driveReq;
            end
         end
      end
   end

   // Speed saturates at the ends instead of wrapping, so a late step cannot reverse the motor
   always_ff @(posedge clock) begin
      for (int a = 0; a < AXES; a++) begin
         if (rstAll) begin
            speed_r[a] <= REG_RESET[SPEED_W-1:0];
         end else if (driveStart_r[a]) begin
            speed_r[a] <= driveSpeed_r;
         end else if (cmdWrite && cmdCode == CMD_SPEED_UP && speedOk[a]) begin
            speed_r[a] <= (SPEED_MAX - speed_r[a] < step_r) ? SPEED_MAX : speed_r[a] + step_r;
         end else if (cmdWrite && cmdCode == CMD_SPEED_DOWN && speedOk[a]) begin
            speed_r[a] <= (speed_r[a] < step_r) ? '0 : speed_r[a] - step_r;
         end
      end
   end

   // ==========================================
   // Timer
   amcd_timer_e timerState_r;
   logic [31:0] timerCount_r;
   logic timerHit;

   assign timerHit = timerState_r == TMR_RUN && timerCount_r == timerLimit_r;

   always_ff @(posedge clock) begin
      if (rstAll) begin
         timerState_r <= TMR_IDLE;
         timerCount_r <= REG_RESET;
         timerExpired <= 1'b0;
      end else begin
         timerExpired <= timerHit;
         if (cmdWrite && cmdCode == CMD_TIMER_START) begin
            timerState_r <= TMR_RUN;
            timerCount_r <= REG_RESET;
         end else if (cmdWrite && cmdCode == CMD_TIMER_STOP) begin
            timerState_r <= TMR_IDLE;
            if (timerState_r == TMR_RUN) begin
               timerCount_r <= REG_RESET;
            end
         end else begin
            case (timerState_r)
               TMR_RUN: begin
                  if (timerHit) begin
                     if (mode3_r[MODE3_REPEAT_BIT]) begin
                        timerCount_r <= REG_RESET;
                     end else begin
                        timerState_r <= TMR_DONE;
                     end
                  end else begin
                     timerCount_r <= timerCount_r + 32'h0000_0001;
                  end
               end
               default: begin
                  timerState_r <= timerState_r;
               end
            endcase
         end
      end
   end

   // ==========================================
   // Deviation clear and split pulse generators
   logic [AXES-1:0] devFire;
   logic [AXES-1:0] devBusy;
   logic [AXES-1:0] splitFire;
   logic [AXES-1:0] splitBusy;
   logic [AXES-1:0] splitActive_r;
   logic [15:0] splitGap_r [AXES];
   logic [AXES-1:0] devPin_r;

   always_comb begin
      for (int a = 0; a < AXES; a++) begin
         devFire[a] = cmdWrite && cmdCode == CMD_DEV_CLEAR && axisSel[a];
         splitFire[a] = splitActive_r[a] && axisIn[a].driving && splitGap_r[a] == 16'h0000;
      end
   end

   for (genvar g = 0; g < AXES; g++) begin : gPulse
      amcd_one_shot uDev (
         .clock(clock),
         .reset(rstAll),
         .fire(devFire[g]),
         .width(devCfg_r[DEV_WIDTH_LSB +: 16]),
         .busy(devBusy[g])
      );
      amcd_one_shot uSplit (
         .clock(clock),
         .reset(rstAll),
         .fire(splitFire[g]),
         .width(splitCfg_r[15:0]),
         .busy(splitBusy[g])
      );
   end

   // Stopping only blocks new pulses; a pulse already high runs its full width
   always_ff @(posedge clock) begin
      for (int a = 0; a < AXES; a++) begin
         if (rstAll) begin
            splitActive_r[a] <= 1'b0;
            splitGap_r[a] <= REG_RESET[15:0];
            devPin_r[a] <= 1'b1;
         end else begin
            devPin_r[a] <= devBusy[a] ~^ devCfg_r[DEV_LEVEL_BIT];
            if (cmdWrite && cmdCode == CMD_SPLIT_START && axisSel[a]) begin
               splitActive_r[a] <= 1'b1;
               splitGap_r[a] <= REG_RESET[15:0];
            end else if (cmdWrite && cmdCode == CMD_SPLIT_STOP && axisSel[a]) begin
               splitActive_r[a] <= 1'b0;
            end else if (splitFire[a]) begin
               splitGap_r[a] <= splitCfg_r[SPLIT_PERIOD_LSB +: 16];
            end else if (splitGap_r[a] != 16'h0000 && axisIn[a].driving) begin
               splitGap_r[a] <= splitGap_r[a] - 16'h0001;
            end
         end
      end
   end

   // ==========================================
   // Status: error and finish flags, page select, maximum finish clear
   logic [AXES-1:0] err_r;
   logic [AXES-1:0] fin_r;
   logic [AXES-1:0] page_r;

   // An event in the same cycle as the clear command is kept
   always_ff @(posedge clock) begin
      for (int a = 0; a < AXES; a++) begin
         if (rstAll) begin
            err_r[a] <= 1'b0;
            fin_r[a] <= 1'b0;
            page_r[a] <= 1'b0;
         end else begin
            if (axisIn[a].errorEvt) begin
               err_r[a] <= 1'b1;
            end else if (cmdWrite && cmdCode == CMD_STATUS_CLEAR) begin
               err_r[a] <= 1'b0;
            end
            if (axisIn[a].finishEvt) begin
               fin_r[a] <= 1'b1;
            end else if (cmdWrite && cmdCode == CMD_STATUS_CLEAR) begin
               fin_r[a] <= 1'b0;
            end
            if (cmdWrite && cmdCode == CMD_PAGE0 && axisSel[a]) begin
               page_r[a] <= 1'b0;
            end else if (cmdWrite && cmdCode == CMD_PAGE1 && axisSel[a]) begin
               page_r[a] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rstAll) begin
         maxFinishClear <= 1'b0;
      end else begin
         maxFinishClear <= cmdWrite && cmdCode == CMD_MAX_FINISH_CLEAR;
      end
   end

   always_comb begin
      for (int a = 0; a < AXES; a++) begin
         axisOut[a].speed = speed_r[a];
         axisOut[a].driveStart = driveStart_r[a];
         axisOut[a].deviationClearPin = devPin_r[a];
         axisOut[a].splitPulsePin = splitBusy[a];
      end
   end

   // ==========================================
   // Read mux; codes not decoded above, NOP among them, change nothing
   function automatic logic [31:0] paged(input int a);
      logic [31:0] v;
      v = '0;
      v[PAGE_BIT] = page_r[a];
      if (page_r[a]) begin
         v[PG1_CONST_BIT] = axisIn[a].constSpeed;
         v[PG1_SPLIT_BIT] = splitActive_r[a];
         v[PG1_TIMER_BIT] = timerState_r == TMR_RUN;
         v[PG1_HOLD_BIT] = hold_r[a];
      end else begin
         v[PG0_DRIVING_BIT] = axisIn[a].driving;
         v[PG0_ERROR_BIT] = err_r[a];
         v[PG0_FINISH_BIT] = fin_r[a];
      end
      return v;
   endfunction

   always_comb begin
      readData = '0;
      if (adr_i == ADDR_COMMAND) begin
         readData[15:0] = {cmdHigh_r, cmdLow_r};
      end else if (adr_i == ADDR_MODE3) begin
         readData = mode3_r;
      end else if (adr_i == ADDR_STEP) begin
         readData[SPEED_W-1:0] = step_r;
      end else if (adr_i == ADDR_DRIVE_SPEED) begin
         readData[SPEED_W-1:0] = driveSpeed_r;
      end else if (adr_i == ADDR_TIMER_LIMIT) begin
         readData = timerLimit_r;
      end else if (adr_i == ADDR_DEV_CFG) begin
         readData = devCfg_r;
      end else if (adr_i == ADDR_SPLIT_CFG) begin
         readData = splitCfg_r;
      end else if (adr_i == ADDR_MAIN_STATUS) begin
         for (int a = 0; a < AXES; a++) begin
            readData[MAIN_DRIVE_LSB + a] = axisIn[a].driving;
            readData[MAIN_ERR_LSB + a] = err_r[a];
         end
      end else if (adr_i == ADDR_ERROR_STATUS) begin
         readData[AXES-1:0] = err_r;
         readData[ERRST_FINISH_LSB +: AXES] = fin_r;
      end else if (adr_i == ADDR_PAGED_X) begin
         readData = paged(0);
      end else if (adr_i == ADDR_PAGED_Y) begin
         readData = paged(1);
      end else if (adr_i == ADDR_SPEED_X) begin
         readData[SPEED_W-1:0] = speed_r[0];
      end else if (adr_i == ADDR_SPEED_Y) begin
         readData[SPEED_W-1:0] = speed_r[1];
      end else if (adr_i == ADDR_TIMER_COUNT) begin
         readData = timerCount_r;
      end
   end

   // Ack stays alive through a command reset so the resetting write completes
   always_ff @(posedge clock) begin
      if (reset) begin
         ack_o <= 1'b0;
         dat_o <= REG_RESET;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
         if (cyc_i && stb_i && !we_i && !ack_o) begin
            dat_o <= readData;
         end
      end
   end
endmodule

// [hw/amcd_pkg.sv]
// Constants, register map and carrier types of the miscellaneous command decoder
package amcd_pkg;
   // ==========================================
   // Sizes
   localparam int AXES = 2;
   localparam int SPEED_W = 16;
   typedef logic [SPEED_W-1:0] amcd_speed_t;

   // ==========================================
   // Command codes, low byte of the command register
   localparam logic [7:0] CMD_SPEED_UP = 8'h70;
   localparam logic [7:0] CMD_SPEED_DOWN = 8'h71;
   localparam logic [7:0] CMD_DEV_CLEAR = 8'h72;
   localparam logic [7:0] CMD_TIMER_START = 8'h73;
   localparam logic [7:0] CMD_TIMER_STOP = 8'h74;
   localparam logic [7:0] CMD_SPLIT_START = 8'h75;
   localparam logic [7:0] CMD_SPLIT_STOP = 8'h76;
   localparam logic [7:0] CMD_HOLD = 8'h77;
   localparam logic [7:0] CMD_RELEASE = 8'h78;
   localparam logic [7:0] CMD_STATUS_CLEAR = 8'h79;
   localparam logic [7:0] CMD_PAGE0 = 8'h7a;
   localparam logic [7:0] CMD_PAGE1 = 8'h7b;
   localparam logic [7:0] CMD_MAX_FINISH_CLEAR = 8'h7c;
   localparam logic [7:0] CMD_NOP = 8'h1f;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] RESET_HIGH_BYTE = 8'h00;

   // ==========================================
   // Register byte addresses
   localparam logic [7:0] ADDR_COMMAND = 8'h00;
   localparam logic [7:0] ADDR_MODE3 = 8'h04;
   localparam logic [7:0] ADDR_STEP = 8'h08;
   localparam logic [7:0] ADDR_DRIVE_SPEED = 8'h0c;
   localparam logic [7:0] ADDR_TIMER_LIMIT = 8'h10;
   localparam logic [7:0] ADDR_DEV_CFG = 8'h14;
   localparam logic [7:0] ADDR_SPLIT_CFG = 8'h18;
   localparam logic [7:0] ADDR_MAIN_STATUS = 8'h1c;
   localparam logic [7:0] ADDR_ERROR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_PAGED_X = 8'h24;
   localparam logic [7:0] ADDR_PAGED_Y = 8'h28;
   localparam logic [7:0] ADDR_SPEED_X = 8'h2c;
   localparam logic [7:0] ADDR_SPEED_Y = 8'h30;
   localparam logic [7:0] ADDR_TIMER_COUNT = 8'h34;

   // ==========================================
   // Field positions
   localparam int MODE3_TRI_OFF_BIT = 13;
   localparam int MODE3_REPEAT_BIT = 14;
   localparam int PAGE_BIT = 15;
   localparam int PG0_DRIVING_BIT = 0;
   localparam int PG0_ERROR_BIT = 1;
   localparam int PG0_FINISH_BIT = 2;
   localparam int PG1_HOLD_BIT = 2;
   localparam int PG1_TIMER_BIT = 3;
   localparam int PG1_SPLIT_BIT = 4;
   localparam int PG1_CONST_BIT = 5;
   localparam int MAIN_DRIVE_LSB = 0;
   localparam int MAIN_ERR_LSB = 4;
   localparam int ERRST_FINISH_LSB = 8;
   localparam int DEV_LEVEL_BIT = 0;
   localparam int DEV_WIDTH_LSB = 8;
   localparam int SPLIT_PERIOD_LSB = 16;

   // ==========================================
   // Reset values
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam amcd_speed_t SPEED_MAX = 16'hffff;

   // ==========================================
   // Carriers
   typedef struct packed {
      logic driving;
      logic sCurve;
      logic constSpeed;
      logic interp;
      logic errorEvt;
      logic finishEvt;
      logic driveReq;
   } amcd_axis_in_s;

   typedef struct packed {
      amcd_speed_t speed;
      logic driveStart;
      logic deviationClearPin;
      logic splitPulsePin;
   } amcd_axis_out_s;

   typedef enum logic [1:0] {
      TMR_IDLE = 2'b00,
      TMR_RUN = 2'b01,
      TMR_DONE = 2'b10
   } amcd_timer_e;
endpackage

// [hw/amcd_one_shot.sv]
// Retriggerable-when-idle one-shot of programmable width
`timescale 1ns/1ps
module amcd_one_shot
   import amcd_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic fire,
   input wire logic [15:0] width,
   output logic busy
);
   logic [15:0] count_r;

   // ==========================================
   // Busy stands for exactly width cycles; a fire while busy is ignored
   always_ff @(posedge clock) begin
      if (reset) begin
         count_r <= REG_RESET[15:0];
         busy <= 1'b0;
      end else if (fire && !busy && width != 16'h0000) begin
         count_r <= width - 16'h0001;
         busy <= 1'b1;
      end else if (busy) begin
         if (count_r == 16'h0000) begin
            busy <= 1'b0;
         end else begin
            count_r <= count_r - 16'h0001;
         end
      end
   end
endmodule

// [testbench/amcd_decoder_checker.sv]
// Port assertions of the command decoder
`timescale 1ns/1ps
module amcd_decoder_checker
   import amcd_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire amcd_axis_in_s [AXES-1:0] axisIn,
   input wire amcd_axis_out_s [AXES-1:0] axisOut,
   input wire logic triangleGuardOff,
   input wire logic maxFinishClear,
   input wire logic timerExpired
);
   // ==========
   // Helpers
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   wire logic take = cyc_i & stb_i & !ack_o;
   wire logic cmdW = take & we_i & (adr_i == ADDR_COMMAND) & sel_i[0];
   // A drive request may legally reload speed, so the no-op check excludes it
   wire logic noReq = !axisIn[0].driveReq & !axisIn[1].driveReq;
   // ==========
   // Assertions
   AST_ACK_NEXT: assert property (take |=> ack_o)
      else $error("ack missing");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("ack too long");
   AST_UNMAPPED: assert property (take && !we_i && adr_i == 8'hfc |=> dat_o == 32'h0)
      else $error("unmapped read not zero");
   AST_MAX_FINISH: assert property (cmdW && dat_i[7:0] == CMD_MAX_FINISH_CLEAR |-> ##[1:2] maxFinishClear)
      else $error("no finish point clear");
   AST_TRIANGLE: assert property (take && we_i && adr_i == ADDR_MODE3 |=> triangleGuardOff == $past(dat_i[13]))
      else $error("triangle guard wrong");
   AST_RESET_OUT: assert property ($fell(reset) |-> axisOut[0].deviationClearPin && !axisOut[0].splitPulsePin
      && axisOut[1].speed == 16'h0 && !triangleGuardOff)
      else $error("outputs not reset");
   AST_NOP: assert property (cmdW && dat_i[7:0] == CMD_NOP && noReq ##1 noReq
      |-> $stable(axisOut[0].speed) ##1 $stable(axisOut[0].speed))
      else $error("no-op changed speed");
   AST_START_PULSE: assert property (axisOut[0].driveStart |=> !axisOut[0].driveStart)
      else $error("start pulse too long");
   // ==========
   // Coverage
   COV_MFC: cover property (maxFinishClear);
   COV_BOTH: cover property (axisOut[0].driveStart && axisOut[1].driveStart);
   COV_TMR: cover property (timerExpired);
endmodule

bind amcd_decoder amcd_decoder_checker u_chk (
   .clock(clock),
   .reset(reset),
   .cyc_i(cyc_i),
   .stb_i(stb_i),
   .we_i(we_i),
   .adr_i(adr_i),
   .sel_i(sel_i),
   .dat_i(dat_i),
   .dat_o(dat_o),
   .ack_o(ack_o),
   .axisIn(axisIn),
   .axisOut(axisOut),
   .triangleGuardOff(triangleGuardOff),
   .maxFinishClear(maxFinishClear),
   .timerExpired(timerExpired)
);

// [testbench/amcd_host.sv]
// Host processor model driving the register bus
`timescale 1ns/1ps
module amcd_host
   import amcd_pkg::*;
(
   input wire logic clock,
   input wire logic ack,
   input wire logic [31:0] datR,
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [7:0] adr,
   output logic [3:0] sel,
   output logic [31:0] datW
);
   // ==========
   // Idle bus
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      datW = 32'h0;
   end
   // ==========
   // Bus cycles
   // Released address and data lines show the inverse of their last value; we and sel keep a stale copy
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] q);
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      datW <= d;
      do @(posedge clock); while (ack !== 1'b1);
      q = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
      adr <= ~a;
      datW <= ~d;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, 4'hf, q);
   endtask
   task automatic cmd(input logic [15:0] c);
      logic [31:0] q;
      xfer(1'b1, ADDR_COMMAND, {16'h0, c}, 4'h3, q);
      repeat (16) @(posedge clock);
   endtask
endmodule

// [testbench/tb_top.sv]
// Self-checking bench of the command decoder
`timescale 1ns/1ps
module tb_top
   import amcd_pkg::*;
;
   logic clock;
   logic reset;
   logic cyc;
   logic stb;
   logic we;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] datW;
   logic [31:0] datR;
   logic ack;
   amcd_axis_in_s [AXES-1:0] axisIn;
   amcd_axis_out_s [AXES-1:0] axisOut;
   logic triangleGuardOff;
   logic maxFinishClear;
   logic timerExpired;
   int failures;
   int comparisons;
   int devLow, tmrCnt, mfcCnt, startX, startBoth, splitRun, splitLast;
   // ==========
   // Instances
   amcd_decoder u_dut (.clock(clock), .reset(reset), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack), .axisIn(axisIn), .axisOut(axisOut),
      .triangleGuardOff(triangleGuardOff), .maxFinishClear(maxFinishClear), .timerExpired(timerExpired));
   amcd_host u_host (.clock(clock), .ack(ack), .datR(datR), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
      .sel(sel), .datW(datW));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // ==========
   // Event monitors
   always @(posedge clock) begin
      if (axisOut[0].deviationClearPin === 1'b0) devLow++;
      if (timerExpired === 1'b1) tmrCnt++;
      if (maxFinishClear === 1'b1) mfcCnt++;
      if (axisOut[0].driveStart === 1'b1) startX++;
      if (axisOut[0].driveStart === 1'b1 && axisOut[1].driveStart === 1'b1) startBoth++;
      if (axisOut[0].splitPulsePin === 1'b1) splitRun++;
      else if (splitRun != 0) begin
         splitLast = splitRun;
         splitRun = 0;
      end
   end
   // ==========
   // Helpers
   task automatic clr();
      devLow = 0;
      tmrCnt = 0;
      mfcCnt = 0;
      startX = 0;
      startBoth = 0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] q;
      u_host.xfer(1'b0, a, 32'h0, 4'hf, q);
      chk(q & m, exp);
   endtask
   task automatic ev(input logic [1:0] ax, input logic [2:0] e);
      @(posedge clock);
      for (int i = 0; i < AXES; i++) if (ax[i]) {axisIn[i].errorEvt, axisIn[i].finishEvt, axisIn[i].driveReq} <= e;
      @(posedge clock);
      for (int i = 0; i < AXES; i++) {axisIn[i].errorEvt, axisIn[i].finishEvt, axisIn[i].driveReq} <= 3'b000;
   endtask
   task automatic end_sim();
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ==========
   // Scenarios
   task automatic t_speed();
      chk({30'h0, axisOut[1].deviationClearPin, axisOut[0].deviationClearPin}, 32'h3);
      rchk(8'hfc, 32'hffffffff, 32'h0);
      @(posedge clock);
      axisIn[0].driving <= 1'b1;
      axisIn[1].driving <= 1'b1;
      u_host.wr(ADDR_STEP, 32'h10);
      u_host.wr(ADDR_DRIVE_SPEED, 32'h100);
      ev(2'b01, 3'b001);
      u_host.cmd(16'h0170);
      rchk(ADDR_SPEED_X, 32'hffff, 32'h110);
      chk({16'h0, axisOut[0].speed}, 32'h110);
      rchk(ADDR_DRIVE_SPEED, 32'hffff, 32'h100);
      rchk(ADDR_SPEED_Y, 32'hffff, 32'h0);
      @(posedge clock);
      axisIn[0].sCurve <= 1'b1;
      axisIn[1].sCurve <= 1'b1;
      u_host.cmd(16'h0171);
      rchk(ADDR_SPEED_X, 32'hffff, 32'h110);
      @(posedge clock);
      axisIn[0].constSpeed <= 1'b1;
      axisIn[1].constSpeed <= 1'b1;
      u_host.cmd(16'h0171);
      u_host.cmd(16'h011f);
      rchk(ADDR_SPEED_X, 32'hffff, 32'h100);
      u_host.cmd(16'h0270);
      rchk(ADDR_SPEED_Y, 32'hffff, 32'h10);
   endtask
   task automatic t_dev_timer();
      u_host.wr(ADDR_DEV_CFG, 32'h0400);
      u_host.wr(ADDR_TIMER_LIMIT, 32'h5);
      clr();
      u_host.cmd(16'h0172);
      chk(devLow, 32'h4);
      u_host.cmd(16'h0173);
      chk(tmrCnt, 32'h1);
      rchk(ADDR_TIMER_COUNT, 32'hffff, 32'h5);
      u_host.wr(ADDR_MODE3, 32'h6000);
      chk({31'h0, triangleGuardOff}, 32'h1);
      clr();
      u_host.cmd(16'h0173);
      chk({31'h0, tmrCnt > 1}, 32'h1);
      u_host.wr(ADDR_TIMER_LIMIT, 32'h3e8);
      u_host.cmd(16'h0174);
      rchk(ADDR_TIMER_COUNT, 32'hffff, 32'h0);
   endtask
   task automatic t_split();
      u_host.wr(ADDR_SPLIT_CFG, 32'h0064_0028);
      u_host.cmd(16'h0175);
      u_host.cmd(16'h017b);
      rchk(ADDR_PAGED_X, 32'h8010, 32'h8010);
      // Stop must land inside a pulse, so wait for the next rising edge of the pin
      for (int i = 0; i < 200 && axisOut[0].splitPulsePin !== 1'b0; i++) @(posedge clock);
      for (int i = 0; i < 200 && axisOut[0].splitPulsePin !== 1'b1; i++) @(posedge clock);
      u_host.cmd(16'h0176);
      repeat (90) @(posedge clock);
      chk(splitLast, 32'h28);
      chk({30'h0, axisOut[1].splitPulsePin, axisOut[0].splitPulsePin}, 32'h0);
      rchk(ADDR_PAGED_X, 32'h8010, 32'h8000);
      u_host.cmd(16'h017a);
      rchk(ADDR_PAGED_X, 32'h8000, 32'h0);
   endtask
   task automatic t_hold_status();
      clr();
      @(posedge clock);
      axisIn[0].interp <= 1'b1;
      axisIn[1].interp <= 1'b1;
      u_host.cmd(16'h0377);
      ev(2'b11, 3'b001);
      repeat (4) @(posedge clock);
      chk(startX, 32'h0);
      u_host.cmd(16'h0378);
      chk(startBoth, 32'h1);
      ev(2'b11, 3'b110);
      @(posedge clock);
      axisIn[0].interp <= 1'b0;
      axisIn[1].interp <= 1'b0;
      axisIn[0].driving <= 1'b0;
      axisIn[1].driving <= 1'b0;
      rchk(ADDR_MAIN_STATUS, 32'h33, 32'h30);
      rchk(ADDR_ERROR_STATUS, 32'h303, 32'h303);
      u_host.cmd(16'h0079);
      rchk(ADDR_MAIN_STATUS, 32'h30, 32'h0);
      rchk(ADDR_ERROR_STATUS, 32'h303, 32'h0);
      u_host.cmd(16'h007c);
      chk(mfcCnt, 32'h1);
   endtask
   task automatic t_soft_reset();
      logic [31:0] q;
      u_host.xfer(1'b1, ADDR_COMMAND, 32'h0, 4'h2, q);
      chk({31'h0, triangleGuardOff}, 32'h1);
      u_host.xfer(1'b1, ADDR_COMMAND, 32'hff, 4'h1, q);
      repeat (8) @(posedge clock);
      chk({31'h0, triangleGuardOff}, 32'h0);
      rchk(ADDR_SPEED_X, 32'hffff, 32'h0);
      rchk(ADDR_DRIVE_SPEED, 32'hffff, 32'h0);
   endtask
   // ==========
   // Main sequence and watchdog
   initial begin
      reset = 1'b1;
      axisIn = '0;
      failures = 0;
      comparisons = 0;
      splitRun = 0;
      splitLast = 0;
      clr();
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_speed();
      t_dev_timer();
      t_split();
      t_hold_status();
      t_soft_reset();
      end_sim();
   end
   initial begin
      #100000;
      failures++;
      end_sim();
   end
endmodule
